/* hcrh_handler.sv */
// hub class request handler: decodes setup requests, streams answers
// assumes the packet engine presents decoded setup fields on sys_clk
// and turns resp_stall into a stall handshake
`default_nettype none

// Function
// - release busy non-periodic translator buffer on request
// - value field: endpoint, address, type, zeros, direction
// - stall release for bad port or nonzero length
// - release of unheld transaction completes without effect
// - descriptor read returns the single hub descriptor
// - return smaller of requested and actual length
// - stall descriptor or status read with bad fields
// - status read: status word then change word
// - status bit 0 shows local supply lost
// - over-current bit only with hub-wide reporting
// - reserved status and change bits read zero
// - status bits not changeable by requests
// - change bits set when status bits change
// - bus reset clears both change bits
// - set feature sets change bits, stalls or ignores
// - clear feature clears change bit, no error
// - selector 0 local power, 1 over-current
// - request codes 0,1,3,6,8 decoded
module hcrh_handler
  import hcrh_pkg::*;
#(
  parameter logic [7:0]  NUM_PORTS     = 8'h04,
  parameter bit          TT_PER_PORT   = 1'b0,
  parameter bit          HUB_OC_REPORT = 1'b1,
  parameter hcrh_setf_t  SET_MODE      = SETF_NOOP,
  parameter logic [7:0]  HUB_DESC_TYPE = 8'h00,
  parameter logic [15:0] HUB_CHAR      = 16'h0000,
  parameter logic [7:0]  PWR_GOOD_TIME = 8'h00,
  parameter logic [7:0]  CTRL_CURRENT  = 8'h00,
  parameter logic [7:0]  REMOVABLE     = 8'h00
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        setup_valid,
  output logic             setup_ready,
  input  wire logic [7:0]  setup_req_type,
  input  wire logic [7:0]  setup_request,
  input  wire logic [15:0] setup_value,
  input  wire logic [15:0] setup_index,
  input  wire logic [15:0] setup_length,
  input  wire logic        hub_configured,
  input  wire logic        bus_reset,
  input  wire logic        local_power_lost_pin,
  input  wire logic        hub_overcurrent_pin,
  input  wire logic        ports_all_off,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [7:0]       tx_data,
  output logic             tx_last,
  output logic             resp_valid,
  output logic             resp_stall,
  output logic             tt_release_valid,
  output logic [7:0]       tt_release_port,
  output logic [6:0]       tt_release_addr,
  output logic [3:0]       tt_release_ep,
  output logic [1:0]       tt_release_type,
  output logic             tt_release_dir
);

  hcrh_chg_if chg_bus ();

  hcrh_status #(
    .HUB_OC_REPORT (HUB_OC_REPORT)
  ) u_status (
    .sys_clk              (sys_clk),
    .rstn                 (rstn),
    .local_power_lost_pin (local_power_lost_pin),
    .hub_overcurrent_pin  (hub_overcurrent_pin),
    .ports_all_off        (ports_all_off),
    .bus_reset            (bus_reset),
    .st                   (chg_bus)
  );

  hcrh_state_t state_reg;
  logic        take;
  logic        dec_err;
  logic        dec_in;
  logic        dec_desc;
  logic        dec_tt;
  logic [15:0] dec_len;
  logic [1:0]  dec_clr;
  logic [1:0]  dec_set;
  logic        sel_ok;
  logic        port_ok;
  logic [1:0]  sel_bits;
  logic        src_desc_reg;
  logic [15:0] remain_reg;
  logic [3:0]  idx_reg;
  logic [31:0] snap_reg;
  logic [7:0]  tx_data_reg;
  logic        stall_reg;
  logic [1:0]  chg_clear_reg;
  logic [1:0]  chg_set_reg;
  logic        tt_valid_reg;
  logic [7:0]  tt_port_reg;
  logic [6:0]  tt_addr_reg;
  logic [3:0]  tt_ep_reg;
  logic [1:0]  tt_type_reg;
  logic        tt_dir_reg;

  // one descriptor, port bitmaps fit one byte each (up to seven ports)
  function automatic logic [7:0] desc_byte(input logic [3:0] idx);
    case (idx)
      4'h0:    desc_byte = HUB_DESC_LEN[7:0];
      4'h1:    desc_byte = HUB_DESC_TYPE;
      4'h2:    desc_byte = NUM_PORTS;
      4'h3:    desc_byte = HUB_CHAR[7:0];
      4'h4:    desc_byte = HUB_CHAR[15:8];
      4'h5:    desc_byte = PWR_GOOD_TIME;
      4'h6:    desc_byte = CTRL_CURRENT;
      4'h7:    desc_byte = REMOVABLE;
      4'h8:    desc_byte = 8'hff;
      default: desc_byte = 8'h00;
    endcase
  endfunction

  // status word low byte first, then change word
  function automatic logic [7:0] resp_byte(input logic is_desc, input logic [3:0] idx,
                                           input logic [31:0] snap);
    if (is_desc)
      resp_byte = desc_byte(idx);
    else
      resp_byte = snap[{idx[1:0], 3'b000} +: 8];
  endfunction

  function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
    min16 = (a < b) ? a : b;
  endfunction

  assign take     = setup_valid && (state_reg == ST_IDLE);
  assign sel_ok   = (setup_value == FSEL_LOCAL_POWER) || (setup_value == FSEL_OVER_CURRENT);
  assign sel_bits = (setup_value == FSEL_OVER_CURRENT) ? 2'b10 : 2'b01;
  // the host names the translator port, or one for a single translator
  assign port_ok  = TT_PER_PORT ? ((setup_index != 16'h0000) && (setup_index <= {8'h00, NUM_PORTS}))
                                : (setup_index == 16'h0001);

  always_comb begin
    dec_err  = 1'b1;
    dec_in   = 1'b0;
    dec_desc = 1'b0;
    dec_tt   = 1'b0;
    dec_len  = 16'h0000;
    dec_clr  = 2'b00;
    dec_set  = 2'b00;
    case (setup_request)
      REQ_GET_STATUS: begin
        if (setup_req_type == RT_HUB_IN) begin
          dec_err = (setup_value != 16'h0000) || (setup_index != 16'h0000)
                 || (setup_length != HUB_STATUS_LEN);
          dec_in  = 1'b1;
          dec_len = HUB_STATUS_LEN;
        end
      end
      REQ_GET_DESCRIPTOR: begin
        if (setup_req_type == RT_HUB_IN) begin
          dec_err  = (setup_value != {HUB_DESC_TYPE, DESC_INDEX_HUB})
                  || (setup_index != 16'h0000);
          dec_in   = 1'b1;
          dec_desc = 1'b1;
          dec_len  = min16(setup_length, HUB_DESC_LEN);
        end
      end
      REQ_CLEAR_FEATURE: begin
        if (setup_req_type == RT_HUB_OUT) begin
          dec_err = !sel_ok || (setup_index != 16'h0000) || (setup_length != 16'h0000);
          dec_clr = sel_bits;
        end
      end
      REQ_SET_FEATURE: begin
        if (setup_req_type == RT_HUB_OUT) begin
          dec_err = !sel_ok || (setup_index != 16'h0000) || (setup_length != 16'h0000)
                 || (SET_MODE == SETF_STALL);
          dec_set = (SET_MODE == SETF_SET) ? sel_bits : 2'b00;
        end
      end
      REQ_TT_RELEASE: begin
        if (setup_req_type == RT_OTHER_OUT) begin
          dec_err = !port_ok || (setup_length != 16'h0000)
                 || (setup_value[TV_RSVD_LSB +: TV_RSVD_W] != 2'b00);
          dec_tt  = 1'b1;
        end
      end
      default: dec_err = 1'b1;
    endcase
    if (!hub_configured)
      dec_err = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (take) begin
            if (!dec_err && dec_in && (dec_len != 16'h0000))
              state_reg <= ST_SEND;
            else
              state_reg <= ST_RESP;                            // zero length descriptor read is not an error
          end
        end
        ST_SEND: begin
          if (tx_ready && (remain_reg == 16'h0001))
            state_reg <= ST_RESP;
        end
        ST_RESP: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // answer length, source and data bytes
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      src_desc_reg <= 1'b0;
      remain_reg   <= 16'h0000;
      idx_reg      <= 4'h0;
      snap_reg     <= 32'h00000000;
      tx_data_reg  <= 8'h00;
    end else if (take) begin
      src_desc_reg <= dec_desc;
      remain_reg   <= dec_len;
      idx_reg      <= 4'h0;
      // snapshot keeps the four bytes coherent while they drain
      snap_reg     <= {chg_bus.status_change, chg_bus.supply_status};
      tx_data_reg  <= dec_desc ? desc_byte(4'h0) : chg_bus.supply_status[7:0];
    end else if ((state_reg == ST_SEND) && tx_ready) begin
      remain_reg   <= remain_reg - 16'h0001;
      idx_reg      <= idx_reg + 4'h1;
      tx_data_reg  <= resp_byte(src_desc_reg, idx_reg + 4'h1, snap_reg);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      stall_reg <= 1'b0;
    else if (take)
      stall_reg <= dec_err;
  end

  // change bit strobes, only for accepted requests
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      chg_clear_reg <= 2'b00;
      chg_set_reg   <= 2'b00;
    end else begin
      chg_clear_reg <= (take && !dec_err) ? dec_clr : 2'b00;
      chg_set_reg   <= (take && !dec_err) ? dec_set : 2'b00;
    end
  end

  // the translator ignores a release for a buffer it does not hold
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tt_valid_reg <= 1'b0;
      tt_port_reg  <= 8'h00;
      tt_addr_reg  <= 7'h00;
      tt_ep_reg    <= 4'h0;
      tt_type_reg  <= 2'h0;
      tt_dir_reg   <= 1'b0;
    end else begin
      tt_valid_reg <= take && dec_tt && !dec_err;
      if (take && dec_tt && !dec_err) begin
        tt_port_reg <= setup_index[7:0];
        tt_ep_reg   <= setup_value[TV_EP_LSB +: TV_EP_W];
        tt_addr_reg <= setup_value[TV_ADDR_LSB +: TV_ADDR_W];
        tt_type_reg <= setup_value[TV_TYPE_LSB +: TV_TYPE_W];
        tt_dir_reg  <= setup_value[TV_DIR_BIT];
      end
    end
  end

  assign chg_bus.chg_clear = chg_clear_reg;
  assign chg_bus.chg_set   = chg_set_reg;

  assign setup_ready      = (state_reg == ST_IDLE);
  assign tx_valid         = (state_reg == ST_SEND);
  assign tx_data          = tx_data_reg;
  assign tx_last          = (state_reg == ST_SEND) && (remain_reg == 16'h0001);
  assign resp_valid       = (state_reg == ST_RESP);
  assign resp_stall       = stall_reg;
  assign tt_release_valid = tt_valid_reg;
  assign tt_release_port  = tt_port_reg;
  assign tt_release_addr  = tt_addr_reg;
  assign tt_release_ep    = tt_ep_reg;
  assign tt_release_type  = tt_type_reg;
  assign tt_release_dir   = tt_dir_reg;

endmodule

`default_nettype wire

/* hcrh_pkg.sv */
// constants, field layouts and types for the hub class request handler
// assumes one clock domain; shared by the handler and its status keeper
`default_nettype none

package hcrh_pkg;

  // request type codes
  localparam logic [7:0] RT_HUB_OUT   = 8'h20;
  localparam logic [7:0] RT_OTHER_OUT = 8'h23;
  localparam logic [7:0] RT_HUB_IN    = 8'ha0;

  // request codes
  localparam logic [7:0] REQ_GET_STATUS     = 8'h00;
  localparam logic [7:0] REQ_CLEAR_FEATURE  = 8'h01;
  localparam logic [7:0] REQ_SET_FEATURE    = 8'h03;
  localparam logic [7:0] REQ_GET_DESCRIPTOR = 8'h06;
  localparam logic [7:0] REQ_TT_RELEASE     = 8'h08;

  // feature selectors for the change bits
  localparam logic [15:0] FSEL_LOCAL_POWER  = 16'h0000;
  localparam logic [15:0] FSEL_OVER_CURRENT = 16'h0001;

  // buffer release value field layout
  localparam int TV_EP_LSB   = 0;
  localparam int TV_EP_W     = 4;
  localparam int TV_ADDR_LSB = 4;
  localparam int TV_ADDR_W   = 7;
  localparam int TV_TYPE_LSB = 11;
  localparam int TV_TYPE_W   = 2;
  localparam int TV_RSVD_LSB = 13;
  localparam int TV_RSVD_W   = 2;
  localparam int TV_DIR_BIT  = 15;

  // status and change word layout
  localparam int STAT_LOCAL_POWER_BIT  = 0;
  localparam int STAT_OVER_CURRENT_BIT = 1;
  localparam int STAT_USED_W           = 2;
  localparam logic [15:0] HUB_SUPPLY_STATUS_RESET = 16'h0000;
  localparam logic [15:0] HUB_STATUS_CHANGE_RESET = 16'h0000;

  localparam logic [15:0] HUB_STATUS_LEN = 16'h0004;
  localparam logic [7:0]  DESC_INDEX_HUB = 8'h00;
  // descriptor with one-byte port bitmaps: seven fixed bytes plus two
  localparam logic [15:0] HUB_DESC_LEN   = 16'h0009;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_RESP = 3'b100
  } hcrh_state_t;

  typedef enum logic [1:0] {
    SETF_STALL = 2'h0,
    SETF_NOOP  = 2'h1,
    SETF_SET   = 2'h2
  } hcrh_setf_t;

endpackage

`default_nettype wire

/* hcrh_chg_if.sv */
// carrier between the request handler and the status keeper
// assumes both ends on sys_clk; strobes are one-cycle pulses
`default_nettype none

interface hcrh_chg_if;
  logic [1:0]  chg_clear;
  logic [1:0]  chg_set;
  logic [15:0] supply_status;
  logic [15:0] status_change;

  modport ctl (
    output chg_clear,
    output chg_set,
    input  supply_status,
    input  status_change
  );

  modport stat (
    input  chg_clear,
    input  chg_set,
    output supply_status,
    output status_change
  );
endinterface

`default_nettype wire

/* hcrh_status.sv */
// hub status and change words, with pin synchronisers
// assumes clear and set strobes from the handler on the same clock
`default_nettype none

module hcrh_status
  import hcrh_pkg::*;
#(
  parameter bit HUB_OC_REPORT = 1'b1
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic local_power_lost_pin,
  input  wire logic hub_overcurrent_pin,
  input  wire logic ports_all_off,
  input  wire logic bus_reset,
  hcrh_chg_if.stat  st
);

  logic [1:0]             pin_meta_reg;
  logic [1:0]             pin_sync_reg;
  logic [STAT_USED_W-1:0] status_reg;
  logic [STAT_USED_W-1:0] status_next;
  logic [STAT_USED_W-1:0] change_reg;
  logic [STAT_USED_W-1:0] change_next;

  // pins are asynchronous to sys_clk
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta_reg <= 2'h0;
      pin_sync_reg <= 2'h0;
    end else begin
      pin_meta_reg <= {hub_overcurrent_pin, local_power_lost_pin};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // status follows hardware only; no request path reaches it
  always_comb begin
    status_next = '0;
    status_next[STAT_LOCAL_POWER_BIT] = pin_sync_reg[0];
    status_next[STAT_OVER_CURRENT_BIT] = HUB_OC_REPORT & pin_sync_reg[1] & ports_all_off;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      status_reg <= HUB_SUPPLY_STATUS_RESET[STAT_USED_W-1:0];
    else
      status_reg <= status_next;
  end

  // a change event in the clearing cycle survives: set wins
  always_comb begin
    change_next = (change_reg & ~st.chg_clear)
                | (status_next ^ status_reg)
                | st.chg_set;
    if (bus_reset)
      change_next = '0;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      change_reg <= HUB_STATUS_CHANGE_RESET[STAT_USED_W-1:0];
    else
      change_reg <= change_next;
  end

  // reserved bits tie to zero
  assign st.supply_status = {14'h0000, status_reg};
  assign st.status_change = {14'h0000, change_reg};

endmodule

`default_nettype wire

/* hcrh_handler_chk.sv */
// concurrent checks on the hub class request handler ports
// assumes binding into hcrh_handler; one clock, async low reset
`default_nettype none

module hcrh_handler_chk
  import hcrh_pkg::*;
#(
  parameter logic [7:0] HUB_DESC_TYPE = 8'h00,
  parameter bit         TT_PER_PORT   = 1'b0
) (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        setup_valid,
  input wire logic        setup_ready,
  input wire logic [7:0]  setup_req_type,
  input wire logic [7:0]  setup_request,
  input wire logic [15:0] setup_value,
  input wire logic [15:0] setup_index,
  input wire logic [15:0] setup_length,
  input wire logic        hub_configured,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_last,
  input wire logic        resp_valid,
  input wire logic        resp_stall,
  input wire logic        tt_release_valid,
  input wire logic [6:0]  tt_release_addr,
  input wire logic [3:0]  tt_release_ep,
  input wire logic [1:0]  tt_release_type,
  input wire logic        tt_release_dir
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        take;
  logic        ok_take;
  logic [15:0] value_q;

  assign take    = setup_valid && setup_ready;
  assign ok_take = take && hub_configured;

  // value captured at take, since the host may scramble it afterwards
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      value_q <= 16'h0000;
    end else if (take) begin
      value_q <= setup_value;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_unconf_stall: assert property (take && !hub_configured |=> resp_valid && resp_stall && !tx_valid)
    else $error("unconfigured request not stalled");
  a_stat_len_bad: assert property (ok_take && setup_req_type == RT_HUB_IN && setup_request == REQ_GET_STATUS
    && setup_length != HUB_STATUS_LEN |=> resp_valid && resp_stall)
    else $error("status read with bad length not stalled");
  a_desc_zero_len: assert property (ok_take && setup_req_type == RT_HUB_IN && setup_request == REQ_GET_DESCRIPTOR
    && setup_value == {HUB_DESC_TYPE, 8'h00} && setup_index == 16'h0000 && setup_length == 16'h0000
    |=> resp_valid && !resp_stall && !tx_valid)
    else $error("zero length descriptor read mishandled");
  a_tt_index_bad: assert property (ok_take && !TT_PER_PORT && setup_req_type == RT_OTHER_OUT
    && setup_request == REQ_TT_RELEASE && setup_index != 16'h0001
    |=> resp_valid && resp_stall && !tt_release_valid)
    else $error("buffer release with bad index not stalled");
  a_tt_resp_ok: assert property (tt_release_valid |-> resp_valid && !resp_stall)
    else $error("buffer release without good completion");
  a_tt_pulse: assert property (ok_take && !TT_PER_PORT && setup_req_type == RT_OTHER_OUT
    && setup_request == REQ_TT_RELEASE && setup_index == 16'h0001 && setup_length == 16'h0000
    && setup_value[14:13] == 2'b00 |=> tt_release_valid)
    else $error("good buffer release not passed on");
  a_tt_fields: assert property (tt_release_valid
    |-> {tt_release_dir, tt_release_type, tt_release_addr, tt_release_ep} == {value_q[15], value_q[12:0]})
    else $error("buffer release fields differ from value");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("answer byte changed before taken");
  a_last_resp: assert property (tx_valid && tx_ready && tx_last |=> resp_valid && !resp_stall && !tx_valid)
    else $error("no completion after final byte");
  a_resp_pulse: assert property (resp_valid |=> !resp_valid ##0 setup_ready)
    else $error("completion not a single pulse");
endmodule

`default_nettype wire

/* hcrh_host.sv */
// host controller model: issues setup requests, sinks answer bytes
// assumes the handler on the same clock; drives 1 ns after rising edges
`default_nettype none

module hcrh_host (
  input  wire logic        sys_clk,
  input  wire logic        setup_ready,
  input  wire logic        tx_valid,
  input  wire logic [7:0]  tx_data,
  input  wire logic        resp_valid,
  input  wire logic        resp_stall,
  output logic             setup_valid,
  output logic [7:0]       setup_req_type,
  output logic [7:0]       setup_request,
  output logic [15:0]      setup_value,
  output logic [15:0]      setup_index,
  output logic [15:0]      setup_length,
  output logic             tx_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rx_q[$];
  logic       last_stall;
  logic       hang;
  logic       slow;

  initial begin
    setup_valid    = 1'b0;
    setup_req_type = 8'h00;
    setup_request  = 8'h00;
    setup_value    = 16'h0000;
    setup_index    = 16'h0000;
    setup_length   = 16'h0000;
    tx_ready       = 1'b1;
    slow           = 1'b0;
  end

  // called 1 ns after a rising edge; returns likewise
  task automatic xfer(input logic [7:0] rt, rq, input logic [15:0] v, ix, ln);
    int n;
    rx_q.delete();
    n = 0;
    setup_req_type = rt;
    setup_request  = rq;
    setup_value    = v;
    setup_index    = ix;
    setup_length   = ln;
    setup_valid    = 1'b1;
    while (!setup_ready && n < 50) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    @(posedge sys_clk);
    #1;
    setup_valid = 1'b0;
    // fields are no longer qualified: scramble so a late sample shows
    setup_value = ~setup_value;
    setup_index = ~setup_index;
    while (!resp_valid && n < 100) begin
      tx_ready = slow ? ~tx_ready : 1'b1;
      if (tx_valid && tx_ready) rx_q.push_back(tx_data);
      @(posedge sys_clk);
      #1;
      n++;
    end
    hang       = !resp_valid;
    last_stall = resp_stall;
    // one idle edge keeps two requests' strobes out of one time step
    @(posedge sys_clk);
    #1;
  endtask
endmodule

`default_nettype wire

/* test_hcrh_handler.sv */
// self-checking bench for hcrh_handler with a host model
// assumes a 200 MHz clock; expected answers come from a bench model
`default_nettype none

module test_hcrh_handler
  import hcrh_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] DESC_TYPE = 8'h5a;
  logic        sys_clk, rstn, hub_configured, bus_reset, local_power_lost_pin, hub_overcurrent_pin;
  logic        ports_all_off, setup_valid, setup_ready, tx_valid, tx_ready, tx_last, resp_valid;
  logic        resp_stall, tt_release_valid, tt_release_dir;
  logic [7:0]  setup_req_type, setup_request, tx_data, tt_release_port, stat, chg;
  logic [15:0] setup_value, setup_index, setup_length, v;
  logic [6:0]  tt_release_addr;
  logic [3:0]  tt_release_ep;
  logic [1:0]  tt_release_type;
  logic [31:0] seed;
  logic [7:0]  exp_q[$];
  logic [7:0]  desc[9];
  int          error_cnt, num_checks, lens[4];

  hcrh_handler #(.HUB_DESC_TYPE(DESC_TYPE)) dut_u (.*);
  hcrh_host host_u (.*);

  always #2.5 sys_clk = ~sys_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic req(input logic [7:0] rt, rq, input logic [15:0] val, ix, ln, input logic st);
    host_u.xfer(rt, rq, val, ix, ln);
    if (host_u.hang !== 1'b0) begin
      error_cnt++;
      conclude();
    end
    check(host_u.last_stall, st);
    check(host_u.rx_q.size(), exp_q.size());
    foreach (exp_q[i]) if (i < host_u.rx_q.size()) check(host_u.rx_q[i], exp_q[i]);
    exp_q.delete();
  endtask

  task automatic stat_read();
    exp_q = '{stat, 8'h00, chg, 8'h00};
    req(RT_HUB_IN, REQ_GET_STATUS, 16'h0000, 16'h0000, HUB_STATUS_LEN, 1'b0);
  endtask

  task automatic settle();
    // two sync stages, status register, change register
    repeat (6) @(posedge sys_clk);
    #1;
  endtask

  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    {hub_configured, bus_reset, local_power_lost_pin, hub_overcurrent_pin, ports_all_off} = 5'h00;
    {error_cnt, num_checks, stat, chg} = '0;
    seed = 32'h211d;
    lens = '{0, 1, 9, 12};
    desc = '{8'h09, DESC_TYPE, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff};
    repeat (3) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    req(RT_HUB_IN, REQ_GET_STATUS, 16'h0000, 16'h0000, HUB_STATUS_LEN, 1'b1);
    $display("test 1 done");
    hub_configured = 1'b1;
    stat_read();
    req(RT_HUB_IN, REQ_GET_STATUS, 16'h0000, 16'h0000, 16'h0002, 1'b1);
    req(RT_HUB_IN, REQ_GET_STATUS, 16'h0001, 16'h0000, HUB_STATUS_LEN, 1'b1);
    $display("test 2 done");
    host_u.slow = 1'b1;
    foreach (lens[k]) begin
      for (int i = 0; i < lens[k] && i < 9; i++) exp_q.push_back(desc[i]);
      req(RT_HUB_IN, REQ_GET_DESCRIPTOR, {DESC_TYPE, 8'h00}, 16'h0000, 16'(lens[k]), 1'b0);
    end
    req(RT_HUB_IN, REQ_GET_DESCRIPTOR, {DESC_TYPE, 8'h00}, 16'h0001, 16'h0009, 1'b1);
    req(RT_HUB_IN, REQ_GET_DESCRIPTOR, {DESC_TYPE, 8'h01}, 16'h0000, 16'h0009, 1'b1);
    host_u.slow = 1'b0;
    $display("test 3 done");
    local_power_lost_pin = 1'b1;
    settle();
    stat = 8'h01;
    chg = 8'h01;
    stat_read();
    req(RT_HUB_OUT, REQ_CLEAR_FEATURE, FSEL_LOCAL_POWER, 16'h0000, 16'h0000, 1'b0);
    chg = 8'h00;
    req(RT_HUB_OUT, REQ_CLEAR_FEATURE, FSEL_LOCAL_POWER, 16'h0000, 16'h0000, 1'b0);
    req(RT_HUB_OUT, REQ_SET_FEATURE, FSEL_OVER_CURRENT, 16'h0000, 16'h0000, 1'b0);
    req(RT_HUB_OUT, REQ_CLEAR_FEATURE, 16'h0005, 16'h0000, 16'h0000, 1'b1);
    stat_read();
    $display("test 4 done");
    hub_overcurrent_pin = 1'b1;
    settle();
    stat_read();
    ports_all_off = 1'b1;
    settle();
    stat = 8'h03;
    chg = 8'h02;
    stat_read();
    bus_reset = 1'b1;
    @(posedge sys_clk);
    #1;
    bus_reset = 1'b0;
    chg = 8'h00;
    stat_read();
    $display("test 5 done");
    repeat (4) begin
      seed = lfsr(seed);
      v = seed[15:0] & 16'h9fff;
      req(RT_OTHER_OUT, REQ_TT_RELEASE, v, 16'h0001, 16'h0000, 1'b0);
      check({tt_release_dir, tt_release_type, tt_release_addr, tt_release_ep}, {v[15], v[12:0]});
      check(tt_release_port, 8'h01);
    end
    req(RT_OTHER_OUT, REQ_TT_RELEASE, v, 16'h0002, 16'h0000, 1'b1);
    req(RT_OTHER_OUT, REQ_TT_RELEASE, v, 16'h0001, 16'h0001, 1'b1);
    req(RT_HUB_IN, 8'h02, 16'h0000, 16'h0000, 16'h0000, 1'b1);
    $display("test 6 done");
    conclude();
  end
endmodule

bind hcrh_handler hcrh_handler_chk #(.HUB_DESC_TYPE(HUB_DESC_TYPE), .TT_PER_PORT(TT_PER_PORT)) chk_u (.*);

`default_nettype wire
